// >>> pgpio_map.svh
// Operation
// - port-7 latch bit 7 always reads back as one.
// - port-7 latch bits 6..0 reset to zero and drive general output pins.
// - port-7 data read: latch where direction is one, pin level otherwise.
// - timer-V select 0000 gives general I/O, otherwise waveform output.
// - timer-V clock and reset pins always feed timer V.
// - serial transmit enable routes transmit data out, overriding direction.
// - serial receive enable makes shared pin the receive input.
// - serial clock pin: high bit input, low bit or sync mode output.
// - timer-W settings take priority over port-8 registers on four pins.
// - timer-W clock pin always feeds timer W.
// - write-only port-8 direction bits 4..0, reset zero, one means output.
// - port-8 latch bits 4..0 reset zero, drive general output pins.
// - port-8 data read: latch where direction is one, pin level otherwise.
// - channel D field 001 or 01x gives timer output, else general I/O.
// - channel C uses the same field decode with its own field.
// - write-only port-7 direction bits 6..0, reset zero, timer-V overrides.
// - channels A and B use the same decode from the other register.
`ifndef PGPIO_MAP_SVH
`define PGPIO_MAP_SVH
`define PGPIO_OFS_P7_DIR   4'h0
`define PGPIO_OFS_P7_DATA  4'h4
`define PGPIO_OFS_P8_DIR   4'h8
`define PGPIO_OFS_P8_DATA  4'hc
`define PGPIO_OFS_FUNC     5'h10
`define PGPIO_OFS_STATUS   5'h14
`define PGPIO_P7_TOP_BIT   8'h80
`define PGPIO_RESP_OKAY    2'b00
`define PGPIO_RESP_DECERR  2'b11
`define PGPIO_TV_GPIO_SEL  4'h0
`define PGPIO_IO_OUT_A     3'b001
`define PGPIO_IO_OUT_B     2'b01
`endif

// >>> pgpio_pkg.sv
package pgpio_pkg;
    typedef enum logic [1:0] {PGPIO_GPIO, PGPIO_PERIPH_OUT, PGPIO_PERIPH_IN} pgpio_func_t;
    typedef logic [2:0] pgpio_io_field_t;
endpackage

// >>> pgpio_io_cell.sv
`timescale 1ns/1ps
`include "pgpio_map.svh"
// one pin: function select, pin driver registers and a two-stage input synchroniser
module pgpio_io_cell (
    input  wire logic                  aclk,       // system clock
    input  wire logic                  aresetn,    // sync reset, active low
    input  wire pgpio_pkg::pgpio_func_t func,      // pin function
    input  wire logic                  dir,        // general direction, 1 = out
    input  wire logic                  latch,      // general output value
    input  wire logic                  periph_out, // peripheral output value
    input  wire logic                  pin_in,     // raw pin level
    output logic                       pin_out,    // pin drive value
    output logic                       pin_oe,     // pin drive enable
    output logic                       pin_sync    // synchronised pin level
);
    import pgpio_pkg::*;
    logic meta_q;
    logic oe_d;
    logic out_d;

    always_comb begin
        oe_d  = 1'b0;
        out_d = latch;
        unique case (func)
            PGPIO_GPIO: begin
                oe_d = dir;
            end
            PGPIO_PERIPH_OUT: begin
                oe_d  = 1'b1;
                out_d = periph_out;
            end
            PGPIO_PERIPH_IN: begin
                oe_d = 1'b0;
            end
            default: begin
                oe_d = 1'b0;
            end
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pin_oe  <= 1'b0;
            pin_out <= 1'b0;
        end else begin
            pin_oe  <= oe_d;
            pin_out <= out_d;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            meta_q   <= 1'b0;
            pin_sync <= 1'b0;
        end else begin
            meta_q   <= pin_in;
            pin_sync <= meta_q;
        end
    end

    a_oe_follows_func: assert property (@(posedge aclk) disable iff (!aresetn)
        (func == PGPIO_PERIPH_OUT) |=> pin_oe && pin_out == $past(periph_out))
        else $error("peripheral output not driven");
    a_input_no_drive: assert property (@(posedge aclk) disable iff (!aresetn)
        (func == PGPIO_PERIPH_IN) |=> !pin_oe)
        else $error("input function drives pin");
endmodule

// >>> pgpio_top.sv
// Our own choices: the placing of the registers and the AXI4-Lite slave port.
`timescale 1ns/1ps
`include "pgpio_map.svh"
module pgpio_top #(
    parameter int P7_W = 7,   // port-7 pins
    parameter int P8_W = 5    // port-8 pins
) (
    input  wire logic             aclk,           // system clock
    input  wire logic             aresetn,        // sync reset, active low
    input  wire logic [4:0]       s_awaddr,       // write address
    input  wire logic             s_awvalid,      // write address valid
    output logic                  s_awready,      // write address ready
    input  wire logic [31:0]      s_wdata,        // write data
    input  wire logic [3:0]       s_wstrb,        // write strobes
    input  wire logic             s_wvalid,       // write data valid
    output logic                  s_wready,       // write data ready
    output logic [1:0]            s_bresp,        // write response
    output logic                  s_bvalid,       // write response valid
    input  wire logic             s_bready,       // write response ready
    input  wire logic [4:0]       s_araddr,       // read address
    input  wire logic             s_arvalid,      // read address valid
    output logic                  s_arready,      // read address ready
    output logic [31:0]           s_rdata,        // read data
    output logic [1:0]            s_rresp,        // read response
    output logic                  s_rvalid,       // read data valid
    input  wire logic             s_rready,       // read data ready
    input  wire logic [3:0]       timer_v_output_select, // timer-V output select
    input  wire logic             timer_v_wave_out,      // timer-V waveform
    output logic                  timer_v_clock_in,      // to timer V
    output logic                  timer_v_reset_in,      // to timer V
    input  wire logic             serial2_tx_data,       // serial transmit data
    input  wire logic             receive_enable_bit,    // serial receive enable
    output logic                  serial2_rx_data,       // to serial receiver
    input  wire logic             clock_source_high_bit, // serial clock source high
    input  wire logic             clock_source_low_bit,  // serial clock source low
    input  wire logic             serial2_sync_mode,     // serial synchronous mode
    input  wire logic             serial2_clock_out,     // serial clock to drive
    output logic                  serial2_clock_pin,     // serial clock from pin
    input  wire pgpio_pkg::pgpio_io_field_t timer_w_io_ctrl_ab_a, // channel A field
    input  wire pgpio_pkg::pgpio_io_field_t timer_w_io_ctrl_ab_b, // channel B field
    input  wire pgpio_pkg::pgpio_io_field_t timer_w_io_ctrl_cd_c, // channel C field
    input  wire pgpio_pkg::pgpio_io_field_t timer_w_io_ctrl_cd_d, // channel D field
    input  wire logic [3:0]       timer_w_out,    // timer-W outputs, D..A at 3..0
    output logic [3:0]            timer_w_in,     // pin levels to timer W
    output logic                  timer_w_clock_in, // to timer W
    input  wire logic [P7_W-1:0]  p7_pin_in,      // port-7 pin levels
    output logic [P7_W-1:0]       p7_pin_out,     // port-7 drive values
    output logic [P7_W-1:0]       p7_pin_oe,      // port-7 drive enables
    input  wire logic [P8_W-1:0]  p8_pin_in,      // port-8 pin levels
    output logic [P8_W-1:0]       p8_pin_out,     // port-8 drive values
    output logic [P8_W-1:0]       p8_pin_oe       // port-8 drive enables
);
    import pgpio_pkg::*;

    logic [P7_W-1:0] port7_direction_q;
    logic [P7_W-1:0] port7_output_latch_q;
    logic [P8_W-1:0] port8_direction_q;
    logic [P8_W-1:0] port8_output_latch_q;
    logic [P7_W-1:0] p7_sync;
    logic [P8_W-1:0] p8_sync;
    pgpio_func_t     p7_func [P7_W];
    pgpio_func_t     p8_func [P8_W];
    logic [P7_W-1:0] p7_periph;
    logic [P8_W-1:0] p8_periph;
    logic [4:0]      awaddr_q;
    logic [31:0]     wdata_q;
    logic [3:0]      wstrb_q;
    logic            aw_have_q;
    logic            w_have_q;
    logic [31:0]     rdata_d;
    logic            rhit_d;
    logic            serial2_tx_pin_enable_q;

    function automatic logic tw_is_out(input pgpio_io_field_t f);
        return (f == `PGPIO_IO_OUT_A) || (f[2:1] == `PGPIO_IO_OUT_B);
    endfunction

    // pin function decode
    always_comb begin
        for (int i = 0; i < P7_W; i++) begin
            p7_func[i] = PGPIO_GPIO;
        end
        p7_periph = '0;
        if (timer_v_output_select != `PGPIO_TV_GPIO_SEL) begin
            p7_func[6]   = PGPIO_PERIPH_OUT;
            p7_periph[6] = timer_v_wave_out;
        end
        if (serial2_tx_pin_enable_q) begin
            p7_func[2]   = PGPIO_PERIPH_OUT;
            p7_periph[2] = serial2_tx_data;
        end
        if (receive_enable_bit) begin
            p7_func[1] = PGPIO_PERIPH_IN;
        end
        if (clock_source_high_bit) begin
            p7_func[0] = PGPIO_PERIPH_IN;
        end else if (clock_source_low_bit || serial2_sync_mode) begin
            p7_func[0]   = PGPIO_PERIPH_OUT;
            p7_periph[0] = serial2_clock_out;
        end
        for (int i = 0; i < P8_W; i++) begin
            p8_func[i] = PGPIO_GPIO;
        end
        p8_periph = '0;
        // timer-W fields win over port-8 direction
        if (tw_is_out(timer_w_io_ctrl_cd_d)) begin
            p8_func[4]   = PGPIO_PERIPH_OUT;
            p8_periph[4] = timer_w_out[3];
        end
        if (tw_is_out(timer_w_io_ctrl_cd_c)) begin
            p8_func[3]   = PGPIO_PERIPH_OUT;
            p8_periph[3] = timer_w_out[2];
        end
        if (tw_is_out(timer_w_io_ctrl_ab_b)) begin
            p8_func[2]   = PGPIO_PERIPH_OUT;
            p8_periph[2] = timer_w_out[1];
        end
        if (tw_is_out(timer_w_io_ctrl_ab_a)) begin
            p8_func[1]   = PGPIO_PERIPH_OUT;
            p8_periph[1] = timer_w_out[0];
        end
    end

    for (genvar i = 0; i < P7_W; i++) begin : g_p7
        pgpio_io_cell u_cell (
            .aclk       (aclk),
            .aresetn    (aresetn),
            .func       (p7_func[i]),
            .dir        (port7_direction_q[i]),
            .latch      (port7_output_latch_q[i]),
            .periph_out (p7_periph[i]),
            .pin_in     (p7_pin_in[i]),
            .pin_out    (p7_pin_out[i]),
            .pin_oe     (p7_pin_oe[i]),
            .pin_sync   (p7_sync[i])
        );
    end
    for (genvar i = 0; i < P8_W; i++) begin : g_p8
        pgpio_io_cell u_cell (
            .aclk       (aclk),
            .aresetn    (aresetn),
            .func       (p8_func[i]),
            .dir        (port8_direction_q[i]),
            .latch      (port8_output_latch_q[i]),
            .periph_out (p8_periph[i]),
            .pin_in     (p8_pin_in[i]),
            .pin_out    (p8_pin_out[i]),
            .pin_oe     (p8_pin_oe[i]),
            .pin_sync   (p8_sync[i])
        );
    end

    // peripheral inputs see the pin regardless of port setup
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            timer_v_clock_in  <= 1'b0;
            timer_v_reset_in  <= 1'b0;
            serial2_rx_data   <= 1'b0;
            serial2_clock_pin <= 1'b0;
            timer_w_in        <= 4'h0;
            timer_w_clock_in  <= 1'b0;
        end else begin
            timer_v_clock_in  <= p7_sync[5];
            timer_v_reset_in  <= p7_sync[4];
            serial2_rx_data   <= p7_sync[1];
            serial2_clock_pin <= p7_sync[0];
            timer_w_in        <= p8_sync[4:1];
            timer_w_clock_in  <= p8_sync[0];
        end
    end

    // write channel: address and data taken in either order
    wire wr_go = aw_have_q && w_have_q && !s_bvalid;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_have_q <= 1'b0;
            w_have_q  <= 1'b0;
            awaddr_q  <= 5'h0;
            wdata_q   <= 32'h0;
            wstrb_q   <= 4'h0;
        end else begin
            if (s_awvalid && s_awready) begin
                aw_have_q <= 1'b1;
                awaddr_q  <= s_awaddr;
            end else if (wr_go) begin
                aw_have_q <= 1'b0;
            end
            if (s_wvalid && s_wready) begin
                w_have_q <= 1'b1;
                wdata_q  <= s_wdata;
                wstrb_q  <= s_wstrb;
            end else if (wr_go) begin
                w_have_q <= 1'b0;
            end
        end
    end

    // readies are registered: each holds next cycle's free condition
    wire aw_take   = s_awvalid && s_awready;
    wire w_take    = s_wvalid && s_wready;
    wire aw_have_d = aw_take || (aw_have_q && !wr_go);
    wire w_have_d  = w_take || (w_have_q && !wr_go);
    wire bvalid_d  = wr_go || (s_bvalid && !s_bready);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_awready <= 1'b0;
            s_wready  <= 1'b0;
        end else begin
            s_awready <= !aw_have_d && !bvalid_d;
            s_wready  <= !w_have_d && !bvalid_d;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_bvalid <= 1'b0;
            s_bresp  <= `PGPIO_RESP_OKAY;
        end else if (wr_go) begin
            s_bvalid <= 1'b1;
            s_bresp  <= (awaddr_q[4:2] > `PGPIO_OFS_STATUS >> 2) ?
                        `PGPIO_RESP_DECERR : `PGPIO_RESP_OKAY;
        end else if (s_bready) begin
            s_bvalid <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            port7_direction_q       <= '0;
            port7_output_latch_q    <= '0;
            port8_direction_q       <= '0;
            port8_output_latch_q    <= '0;
            serial2_tx_pin_enable_q <= 1'b0;
        end else if (wr_go && wstrb_q[0]) begin
            unique case ({2'b00, awaddr_q[4:2], 2'b00})
                7'(`PGPIO_OFS_P7_DIR): port7_direction_q <= wdata_q[P7_W-1:0];
                7'(`PGPIO_OFS_P7_DATA): port7_output_latch_q <= wdata_q[P7_W-1:0];
                7'(`PGPIO_OFS_P8_DIR): port8_direction_q <= wdata_q[P8_W-1:0];
                7'(`PGPIO_OFS_P8_DATA): port8_output_latch_q <= wdata_q[P8_W-1:0];
                7'(`PGPIO_OFS_FUNC): serial2_tx_pin_enable_q <= wdata_q[0];
                default: begin
                end
            endcase
        end
    end

    // read decode; direction registers are write-only and read as zero
    always_comb begin
        rdata_d = 32'h0;
        rhit_d  = 1'b1;
        unique case ({2'b00, s_araddr[4:2], 2'b00})
            7'(`PGPIO_OFS_P7_DIR): rdata_d = 32'h0;
            7'(`PGPIO_OFS_P7_DATA): rdata_d = 32'(`PGPIO_P7_TOP_BIT)
                | 32'((port7_direction_q & port7_output_latch_q)
                | (~port7_direction_q & p7_sync));
            7'(`PGPIO_OFS_P8_DIR): rdata_d = 32'h0;
            7'(`PGPIO_OFS_P8_DATA): rdata_d = 32'((port8_direction_q & port8_output_latch_q)
                | (~port8_direction_q & p8_sync));
            7'(`PGPIO_OFS_FUNC): rdata_d = {31'h0, serial2_tx_pin_enable_q};
            7'(`PGPIO_OFS_STATUS): rdata_d = {20'h0, p8_pin_oe, p7_pin_oe};
            default: rhit_d = 1'b0;
        endcase
    end

    // arready registered as the inverse of next cycle's rvalid
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_arready <= 1'b0;
        end else begin
            s_arready <= !((s_arvalid && s_arready) || (s_rvalid && !s_rready));
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_rvalid <= 1'b0;
            s_rdata  <= 32'h0;
            s_rresp  <= `PGPIO_RESP_OKAY;
        end else if (s_arvalid && s_arready) begin
            s_rvalid <= 1'b1;
            s_rdata  <= rdata_d;
            s_rresp  <= rhit_d ? `PGPIO_RESP_OKAY : `PGPIO_RESP_DECERR;
        end else if (s_rready) begin
            s_rvalid <= 1'b0;
        end
    end

    a_p7_top_one: assert property (@(posedge aclk) disable iff (!aresetn)
        s_arvalid && s_arready && {s_araddr[4:2], 2'b00} == 5'(`PGPIO_OFS_P7_DATA)
        |=> s_rdata[7])
        else $error("port-7 top bit not one");
    a_p8_upper_zero: assert property (@(posedge aclk) disable iff (!aresetn)
        s_arvalid && s_arready && {s_araddr[4:2], 2'b00} == 5'(`PGPIO_OFS_P8_DATA)
        |=> s_rdata[7:5] == 3'h0)
        else $error("port-8 reserved bits nonzero");
    a_tv_wave_drives: assert property (@(posedge aclk) disable iff (!aresetn)
        timer_v_output_select != `PGPIO_TV_GPIO_SEL |=> p7_pin_oe[6])
        else $error("timer-V wave pin not driven");
    a_tx_drives: assert property (@(posedge aclk) disable iff (!aresetn)
        serial2_tx_pin_enable_q |=> p7_pin_oe[2] && p7_pin_out[2] == $past(serial2_tx_data))
        else $error("transmit pin not driven");
    a_rx_input: assert property (@(posedge aclk) disable iff (!aresetn)
        receive_enable_bit |=> !p7_pin_oe[1])
        else $error("receive pin driven");
    a_sck_input: assert property (@(posedge aclk) disable iff (!aresetn)
        clock_source_high_bit |=> !p7_pin_oe[0])
        else $error("clock input pin driven");
    a_tw_d_out: assert property (@(posedge aclk) disable iff (!aresetn)
        timer_w_io_ctrl_cd_d == `PGPIO_IO_OUT_A |=> p8_pin_oe[4])
        else $error("channel D not output");
    a_tw_clk_feed: assert property (@(posedge aclk) disable iff (!aresetn)
        ##3 timer_w_clock_in == $past(p8_pin_in[0], 3))
        else $error("timer-W clock not fed");
    a_gpio_dir: assert property (@(posedge aclk) disable iff (!aresetn)
        timer_w_io_ctrl_cd_c[2] |=> p8_pin_oe[3] == $past(port8_direction_q[3]))
        else $error("channel C general I/O wrong");
    c_write_done: cover property (@(posedge aclk) s_bvalid && s_bready);
    c_read_done: cover property (@(posedge aclk) s_rvalid && s_rready);
    c_tw_out: cover property (@(posedge aclk) p8_pin_oe[1] && timer_w_io_ctrl_ab_a[1]);
endmodule

// >>> pgpio_board.sv
`timescale 1ns/1ps
// board side of both ports: a driven pin shows the drive value, a released pin
// shows the level the bench puts on the board wire
module pgpio_board (
    input  wire logic [6:0] p7_out, // port-7 drive values
    input  wire logic [6:0] p7_oe,  // port-7 drive enables
    input  wire logic [6:0] p7_ext, // port-7 board levels
    output logic      [6:0] p7_lvl, // port-7 wire levels
    input  wire logic [4:0] p8_out, // port-8 drive values
    input  wire logic [4:0] p8_oe,  // port-8 drive enables
    input  wire logic [4:0] p8_ext, // port-8 board levels
    output logic      [4:0] p8_lvl  // port-8 wire levels
);
    assign p7_lvl = (p7_oe & p7_out) | (~p7_oe & p7_ext);
    assign p8_lvl = (p8_oe & p8_out) | (~p8_oe & p8_ext);
endmodule

// >>> testbench.sv
`timescale 1ns/1ps
`include "pgpio_map.svh"
module testbench;
    import pgpio_pkg::*;
    localparam logic [4:0] A7DIR = 5'(`PGPIO_OFS_P7_DIR);
    localparam logic [4:0] A7DAT = 5'(`PGPIO_OFS_P7_DATA);
    localparam logic [4:0] A8DIR = 5'(`PGPIO_OFS_P8_DIR);
    localparam logic [4:0] A8DAT = 5'(`PGPIO_OFS_P8_DATA);
    localparam logic [4:0] AFUNC = `PGPIO_OFS_FUNC;
    logic            aclk, aresetn, tmr;
    logic [4:0]      s_awaddr, s_araddr;
    logic            s_awvalid, s_awready, s_wvalid, s_wready, s_bvalid, s_bready;
    logic            s_arvalid, s_arready, s_rvalid, s_rready;
    logic [31:0]     s_wdata, s_rdata, rd;
    logic [3:0]      s_wstrb, tv_sel, tw_out, tw_in;
    logic [1:0]      s_bresp, s_rresp, rsp;
    logic            tv_wave, tv_clk, tv_rst, tx_d, rx_en, rx_d;
    logic            ck_hi, ck_lo, ck_sync, ck_out, ck_pin, tw_clk;
    pgpio_io_field_t tw_f [4];
    logic [6:0]      p7_in, p7_out, p7_oe, p7_ext;
    logic [4:0]      p8_in, p8_out, p8_oe, p8_ext;
    int              num_errors, check_count;

    pgpio_top i_pgpio_top (.aclk(aclk), .aresetn(aresetn),
        .s_awaddr(s_awaddr), .s_awvalid(s_awvalid), .s_awready(s_awready),
        .s_wdata(s_wdata), .s_wstrb(s_wstrb), .s_wvalid(s_wvalid), .s_wready(s_wready),
        .s_bresp(s_bresp), .s_bvalid(s_bvalid), .s_bready(s_bready),
        .s_araddr(s_araddr), .s_arvalid(s_arvalid), .s_arready(s_arready),
        .s_rdata(s_rdata), .s_rresp(s_rresp), .s_rvalid(s_rvalid), .s_rready(s_rready),
        .timer_v_output_select(tv_sel), .timer_v_wave_out(tv_wave),
        .timer_v_clock_in(tv_clk), .timer_v_reset_in(tv_rst),
        .serial2_tx_data(tx_d), .receive_enable_bit(rx_en), .serial2_rx_data(rx_d),
        .clock_source_high_bit(ck_hi), .clock_source_low_bit(ck_lo),
        .serial2_sync_mode(ck_sync), .serial2_clock_out(ck_out), .serial2_clock_pin(ck_pin),
        .timer_w_io_ctrl_ab_a(tw_f[0]), .timer_w_io_ctrl_ab_b(tw_f[1]),
        .timer_w_io_ctrl_cd_c(tw_f[2]), .timer_w_io_ctrl_cd_d(tw_f[3]),
        .timer_w_out(tw_out), .timer_w_in(tw_in), .timer_w_clock_in(tw_clk),
        .p7_pin_in(p7_in), .p7_pin_out(p7_out), .p7_pin_oe(p7_oe),
        .p8_pin_in(p8_in), .p8_pin_out(p8_out), .p8_pin_oe(p8_oe));

    pgpio_board i_pgpio_board (.p7_out(p7_out), .p7_oe(p7_oe), .p7_ext(p7_ext),
        .p7_lvl(p7_in), .p8_out(p8_out), .p8_oe(p8_oe), .p8_ext(p8_ext), .p8_lvl(p8_in));

    initial begin
        aclk = 1'b0;
        forever #20 aclk = ~aclk;
    end

    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            num_errors++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // pin levels pass a two-stage synchroniser and a registered mux
    task automatic settle();
        repeat (6) @(posedge aclk);
        @(negedge aclk);
    endtask

    task automatic wr(input logic [4:0] a, input logic [31:0] d);
        logic aw, w, bv;
        bv = 1'b0;
        @(posedge aclk);
        s_awaddr <= a;
        s_wdata <= d;
        {s_awvalid, s_wvalid, s_bready} <= 3'b111;
        while (!bv) begin
            @(negedge aclk);
            aw = s_awvalid && s_awready;
            w = s_wvalid && s_wready;
            bv = s_bvalid;
            rsp = s_bresp;
            @(posedge aclk);
            if (aw) s_awvalid <= 1'b0;
            if (w) s_wvalid <= 1'b0;
        end
        s_bready <= 1'b0;
    endtask

    task automatic rdt(input logic [4:0] a);
        logic ar, rv;
        rv = 1'b0;
        @(posedge aclk);
        s_araddr <= a;
        {s_arvalid, s_rready} <= 2'b11;
        while (!rv) begin
            @(negedge aclk);
            ar = s_arvalid && s_arready;
            rv = s_rvalid;
            rd = s_rdata;
            rsp = s_rresp;
            @(posedge aclk);
            if (ar) s_arvalid <= 1'b0;
        end
        s_rready <= 1'b0;
    endtask

    task automatic ckc(input logic h, input logic l, input logic s, input logic eo,
                       input logic eout);
        @(posedge aclk);
        {ck_hi, ck_lo, ck_sync} <= {h, l, s};
        settle();
        chk(32'(p7_oe[0]), 32'(eo));
        if (eo) chk(32'(p7_out[0]), 32'(eout));
    endtask

    initial begin
        repeat (5000) @(posedge aclk);
        num_errors++;
        report_and_stop();
    end

    initial begin
        aresetn = 1'b0;
        {s_awvalid, s_wvalid, s_bready, s_arvalid, s_rready} = '0;
        {s_awaddr, s_araddr, s_wdata} = '0;
        s_wstrb = 4'hf;
        {tv_sel, tv_wave, tx_d, rx_en, ck_hi, ck_lo, ck_sync, tw_out} = '0;
        ck_out = 1'b1;
        tw_f = '{default: '0};
        p7_ext = 7'h55;
        p8_ext = 5'h0a;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        settle();
        rdt(A7DAT); chk(rd, 32'hd5);
        rdt(A8DAT); chk(rd, 32'h0a);
        rdt(A7DIR); chk(rd, 32'h00);
        rdt(A8DIR); chk(rd, 32'h00);
        chk(32'({p7_oe, p8_oe}), 32'h0);
        chk(32'({tv_clk, tv_rst, tw_clk}), 32'b010);
        wr(A7DAT, 32'h2a);
        chk(32'(rsp), 32'(`PGPIO_RESP_OKAY));
        wr(A7DIR, 32'h7f);
        settle();
        chk(32'(p7_oe), 32'h7f);
        chk(32'(p7_out), 32'h2a);
        chk(32'({tv_clk, tv_rst}), 32'b10);
        rdt(A7DAT); chk(rd, 32'haa);
        wr(A7DIR, 32'h0f);
        settle();
        rdt(A7DAT); chk(rd, 32'hda);
        @(posedge aclk);
        tv_sel <= 4'h3;
        tv_wave <= 1'b1;
        settle();
        chk(32'({p7_oe[6], p7_out[6]}), 32'b11);
        @(posedge aclk);
        tv_sel <= 4'h8;
        tv_wave <= 1'b0;
        settle();
        chk(32'({p7_oe[6], p7_out[6]}), 32'b10);
        @(posedge aclk);
        tv_sel <= `PGPIO_TV_GPIO_SEL;
        settle();
        chk(32'(p7_oe[6]), 32'h0);
        wr(A7DIR, 32'h03);
        wr(AFUNC, 32'h1);
        rdt(AFUNC); chk(rd, 32'h1);
        @(posedge aclk);
        tx_d <= 1'b1;
        settle();
        chk(32'(p7_oe), 32'h07);
        chk(32'(p7_out[2]), 32'h1);
        @(posedge aclk);
        rx_en <= 1'b1;
        settle();
        chk(32'({p7_oe[1], rx_d}), 32'b00);
        @(posedge aclk);
        p7_ext <= 7'h57;
        settle();
        chk(32'(rx_d), 32'h1);
        ckc(1'b1, 1'b0, 1'b0, 1'b0, 1'b0);
        chk(32'(ck_pin), 32'h1);
        ckc(1'b0, 1'b1, 1'b0, 1'b1, 1'b1);
        ckc(1'b0, 1'b0, 1'b1, 1'b1, 1'b1);
        ckc(1'b0, 1'b0, 1'b0, 1'b1, 1'b0);
        wr(A8DAT, 32'hff);
        wr(A8DIR, 32'h1f);
        settle();
        chk(32'({p8_oe, p8_out}), 32'h3ff);
        chk(32'(tw_clk), 32'h1);
        rdt(A8DAT); chk(rd, 32'h1f);
        wr(A8DIR, 32'h03);
        settle();
        rdt(A8DAT); chk(rd, 32'h0b);
        for (int d = 0; d < 2; d++) begin
            wr(A8DIR, (d != 0) ? 32'h1e : 32'h0);
            for (int ch = 0; ch < 4; ch++) begin
                for (int f = 0; f < 8; f++) begin
                    @(posedge aclk);
                    tw_f[ch] <= 3'(f);
                    settle();
                    tmr = (f == 1) || (f[2:1] == 2'b01);
                    chk(32'(p8_oe[ch+1]), 32'(tmr || d != 0));
                    if (tmr || d != 0) chk(32'(p8_out[ch+1]), 32'(!tmr));
                    if (!tmr) chk(32'(tw_in[ch]), (d != 0) ? 32'h1 : 32'(p8_ext[ch+1]));
                end
            end
        end
        rdt(5'h18); chk(32'(rsp), 32'(`PGPIO_RESP_DECERR));
        wr(5'h1c, 32'h0); chk(32'(rsp), 32'(`PGPIO_RESP_DECERR));
        report_and_stop();
    end
endmodule
